//--- design/ios_indicator_selector.sv
// three indicator outputs with programmable sources and stretching
//
// Operation
// RULE1: first source field picks speed/tx/rx/col/link/duplex/activity; defaults to speed.
// RULE2: codes 1000 on, 1001 off, 1010 fast blink, 1011 slow blink.
// RULE3: tx, rx, collision, activity are stretched; others follow source continuously.
// RULE4: second source field, same codes, resets to link status.
// RULE5: third source field, same codes, resets to receive status.
// RULE6: code 1100 solid on with link, toggles on receive activity.
// RULE7: code 1101 solid on with link, toggles on receive or transmit.
// RULE8: code 1110 solid on in full duplex, toggles on collision.
// RULE9: software must not program unused codes 0110 or 1111.
// RULE10: duration field picks 30, 60 or 100 ms minimum; 11 reserved; resets 00.
// RULE11: one enable bit turns stretching on or off for all; resets to 1.
// RULE12: combined displays always stretch, whatever the enable bit says.
// RULE13: fast and slow blink periods derive from the clock, slow longer.
`timescale 1ns/1ps
`default_nettype none
module ios_indicator_selector
#(
   parameter int unsigned STRETCH0 = ios_pkg::STRETCH0_CYC,
   parameter int unsigned STRETCH1 = ios_pkg::STRETCH1_CYC,
   parameter int unsigned STRETCH2 = ios_pkg::STRETCH2_CYC,
   parameter int unsigned FAST_HALF = ios_pkg::FAST_HALF_CYC,
   parameter int unsigned SLOW_HALF = ios_pkg::SLOW_HALF_CYC
)
(
   input  wire logic                   sys_clk,
   input  wire logic                   reset_n,
   input  wire logic [4:0]             reg_addr,
   input  wire logic                   reg_wr_en,
   input  wire logic [15:0]            reg_wr_data,
   output logic [15:0]                 reg_rd_data,
   input  wire ios_pkg::ios_status_type status,
   output logic [ios_pkg::NUM_IND-1:0] indicator_on
);
   import ios_pkg::*;

   // ************************************************************
   // declarations
   // ************************************************************
   logic [15:0]         cfg_reg;
   logic [15:0]         cfg_next;
   logic [15:0]         rd_reg;
   logic [15:0]         rd_next;
   logic [NUM_IND-1:0]  ind_reg;
   logic [NUM_IND-1:0]  ind_next;
   logic [3:0]          src [NUM_IND];
   logic [1:0]          dur_sel;
   logic                stretch_en;
   logic [CNT_W-1:0]    duration;
   ios_events_type      raw_ev;
   ios_events_type      str_ev;
   logic                fast_blink;
   logic                slow_blink;
   logic                wrote_reg;

   // ************************************************************
   // config fields
   // ************************************************************
   assign src[0]     = cfg_reg[FIRST_SRC_LSB +: 4];  // RULE1
   assign src[1]     = cfg_reg[SECOND_SRC_LSB +: 4]; // RULE4
   assign src[2]     = cfg_reg[THIRD_SRC_LSB +: 4];  // RULE5
   assign dur_sel    = cfg_reg[DUR_SEL_LSB +: 2];
   assign stretch_en = cfg_reg[STRETCH_EN_BIT];

   // reserved 11 keeps the longest duration
   function automatic logic [CNT_W-1:0] pick_duration(input logic [1:0] sel);
      case (sel)
         2'h0:    pick_duration = CNT_W'(STRETCH0);
         2'h1:    pick_duration = CNT_W'(STRETCH1);
         default: pick_duration = CNT_W'(STRETCH2);
      endcase
   endfunction

   assign duration = pick_duration(dur_sel); // RULE10

   // ************************************************************
   // register access
   // ************************************************************
   always_comb
   begin
      cfg_next = cfg_reg;
      if (reg_wr_en && reg_addr == CFG_ADDR)
         cfg_next = reg_wr_data & CFG_WR_MASK;
      rd_next = 16'h0000;
      if (reg_addr == CFG_ADDR)
         rd_next = cfg_reg;
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cfg_reg <= CFG_RESET; // RULE4 RULE5 RULE10 RULE11
         rd_reg  <= 16'h0000;
      end
      else
      begin
         cfg_reg <= cfg_next;
         rd_reg  <= rd_next;
      end
   end

   assign reg_rd_data = rd_reg;

   // ************************************************************
   // event stretching
   // ************************************************************
   assign raw_ev.tx  = status.tx_active;
   assign raw_ev.rx  = status.rx_active;
   assign raw_ev.col = status.collision;
   assign raw_ev.act = status.tx_active || status.rx_active;

   ios_stretcher u_str_tx
   (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .event_in  (raw_ev.tx),
      .duration  (duration),
      .stretched (str_ev.tx)
   );

   ios_stretcher u_str_rx
   (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .event_in  (raw_ev.rx),
      .duration  (duration),
      .stretched (str_ev.rx)
   );

   ios_stretcher u_str_col
   (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .event_in  (raw_ev.col),
      .duration  (duration),
      .stretched (str_ev.col)
   );

   ios_stretcher u_str_act
   (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .event_in  (raw_ev.act),
      .duration  (duration),
      .stretched (str_ev.act)
   );

   // ************************************************************
   // blink patterns
   // ************************************************************
   ios_blinker #(.HALF_CYC(FAST_HALF)) u_fast
   (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .blink   (fast_blink)
   );

   ios_blinker #(.HALF_CYC(SLOW_HALF)) u_slow
   (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .blink   (slow_blink)
   );

   // ************************************************************
   // source selection
   // ************************************************************
   function automatic logic show(input logic [3:0] code);
      logic tx_v;
      logic rx_v;
      logic col_v;
      logic act_v;
      tx_v  = stretch_en ? str_ev.tx : raw_ev.tx;   // RULE11
      rx_v  = stretch_en ? str_ev.rx : raw_ev.rx;
      col_v = stretch_en ? str_ev.col : raw_ev.col;
      act_v = stretch_en ? str_ev.act : raw_ev.act;
      case (code)
         SRC_SPEED:    show = status.speed_100;   // RULE1
         SRC_TX:       show = tx_v;               // RULE3
         SRC_RX:       show = rx_v;
         SRC_COL:      show = col_v;
         SRC_LINK:     show = status.link_up;
         SRC_DUPLEX:   show = status.full_duplex;
         SRC_ACT:      show = act_v;
         SRC_ON:       show = 1'b1;               // RULE2
         SRC_OFF:      show = 1'b0;
         SRC_FAST:     show = fast_blink;
         SRC_SLOW:     show = slow_blink;         // RULE13
         SRC_LINK_RX:  show = status.link_up ^ str_ev.rx;       // RULE6 RULE12
         SRC_LINK_ACT: show = status.link_up ^ str_ev.act;      // RULE7 RULE12
         SRC_DUP_COL:  show = status.full_duplex ^ str_ev.col;  // RULE8 RULE12
         default:      show = 1'b0;
      endcase
   endfunction

   always_comb
   begin
      for (int i = 0; i < NUM_IND; i++)
         ind_next[i] = show(src[i]);
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         ind_reg <= '0;
      else
         ind_reg <= ind_next;
   end

   assign indicator_on = ind_reg;

   // ************************************************************
   // checks
   // ************************************************************
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         wrote_reg <= 1'b0;
      else if (reg_wr_en && reg_addr == CFG_ADDR)
         wrote_reg <= 1'b1;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   property p_defaults;
      !wrote_reg |-> (src[0] == SRC_SPEED && src[1] == SRC_LINK
                      && src[2] == SRC_RX && dur_sel == 2'h0 && stretch_en);
   endproperty
   a_defaults: assert property (p_defaults) else $error("reset defaults wrong"); // RULE4

   property p_speed;
      (src[0] == SRC_SPEED) |=> (indicator_on[0] == $past(status.speed_100));
   endproperty
   a_speed: assert property (p_speed) else $error("speed not shown"); // RULE1

   property p_forced;
      (src[0] == SRC_ON && src[1] == SRC_OFF) |=> (indicator_on[0] && !indicator_on[1]);
   endproperty
   a_forced: assert property (p_forced) else $error("forced level wrong"); // RULE2

   property p_unstretched;
      (src[2] == SRC_RX && !stretch_en) |=> (indicator_on[2] == $past(status.rx_active));
   endproperty
   a_unstretched: assert property (p_unstretched) else $error("stretch not off"); // RULE11

   property p_stretched;
      (src[2] == SRC_RX && stretch_en && str_ev.rx) |=> indicator_on[2];
   endproperty
   a_stretched: assert property (p_stretched) else $error("rx not stretched"); // RULE3

   property p_link_rx;
      (src[0] == SRC_LINK_RX) |=> (indicator_on[0] == $past(status.link_up ^ str_ev.rx));
   endproperty
   a_link_rx: assert property (p_link_rx) else $error("link/rx wrong"); // RULE6

   property p_link_act;
      (src[1] == SRC_LINK_ACT && !stretch_en)
         |=> (indicator_on[1] == $past(status.link_up ^ str_ev.act));
   endproperty
   a_link_act: assert property (p_link_act) else $error("link/act wrong"); // RULE12

   property p_dup_col;
      (src[2] == SRC_DUP_COL) |=> (indicator_on[2] == $past(status.full_duplex ^ str_ev.col));
   endproperty
   a_dup_col: assert property (p_dup_col) else $error("duplex/col wrong"); // RULE8

   property p_act;
      (src[0] == SRC_ACT && stretch_en) |=> (indicator_on[0] == $past(str_ev.act));
   endproperty
   a_act: assert property (p_act) else $error("activity wrong"); // RULE3

   property p_duration;
      (reg_wr_en && reg_addr == CFG_ADDR && reg_wr_data[3:2] == 2'h1)
         |=> (duration == CNT_W'(STRETCH1));
   endproperty
   a_duration: assert property (p_duration) else $error("duration not chosen"); // RULE10

   property p_collision;
      (src[0] == SRC_COL && !stretch_en) |=> (indicator_on[0] == $past(status.collision));
   endproperty
   a_collision: assert property (p_collision) else $error("collision not raw"); // RULE11

   property p_fast;
      (src[0] == SRC_FAST) |=> (indicator_on[0] == $past(fast_blink));
   endproperty
   a_fast: assert property (p_fast) else $error("fast blink not shown"); // RULE2

   property p_slow;
      (src[1] == SRC_SLOW) |=> (indicator_on[1] == $past(slow_blink));
   endproperty
   a_slow: assert property (p_slow) else $error("slow blink not shown"); // RULE13

   property p_third_on;
      (src[2] == SRC_ON) |=> indicator_on[2];
   endproperty
   a_third_on: assert property (p_third_on) else $error("third forced on wrong"); // RULE5

   c_link_blink: cover property (src[0] == SRC_LINK_RX && status.link_up ##1 str_ev.rx);
   c_fast: cover property (src[1] == SRC_FAST && $changed(fast_blink));
   c_cfg_write: cover property (reg_wr_en && reg_addr == CFG_ADDR);
   c_slow: cover property (src[1] == SRC_SLOW && $changed(slow_blink));
   c_dup_col: cover property (src[2] == SRC_DUP_COL && status.collision);

endmodule // ios_indicator_selector
`default_nettype wire

//--- common/ios_pkg.sv
// shared constants and types for the indicator output selector
package ios_pkg;

   // ************************************************************
   // management register map
   // ************************************************************
   localparam logic [4:0]  CFG_ADDR      = 5'h14;
   localparam logic [15:0] CFG_RESET     = 16'h0422;
   localparam logic [15:0] CFG_WR_MASK   = 16'hfffe;
   localparam int          FIRST_SRC_LSB = 12;
   localparam int          SECOND_SRC_LSB = 8;
   localparam int          THIRD_SRC_LSB = 4;
   localparam int          DUR_SEL_LSB   = 2;
   localparam int          STRETCH_EN_BIT = 1;
   localparam int          NUM_IND       = 3;

   // ************************************************************
   // source codes
   // ************************************************************
   localparam logic [3:0] SRC_SPEED     = 4'h0;
   localparam logic [3:0] SRC_TX        = 4'h1;
   localparam logic [3:0] SRC_RX        = 4'h2;
   localparam logic [3:0] SRC_COL       = 4'h3;
   localparam logic [3:0] SRC_LINK      = 4'h4;
   localparam logic [3:0] SRC_DUPLEX    = 4'h5;
   localparam logic [3:0] SRC_ACT       = 4'h7;
   localparam logic [3:0] SRC_ON        = 4'h8;
   localparam logic [3:0] SRC_OFF       = 4'h9;
   localparam logic [3:0] SRC_FAST      = 4'ha;
   localparam logic [3:0] SRC_SLOW      = 4'hb;
   localparam logic [3:0] SRC_LINK_RX   = 4'hc;
   localparam logic [3:0] SRC_LINK_ACT  = 4'hd;
   localparam logic [3:0] SRC_DUP_COL   = 4'he;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_HZ        = 50_000_000;
   localparam int STRETCH0_MS   = 30;
   localparam int STRETCH1_MS   = 60;
   localparam int STRETCH2_MS   = 100;
   localparam int FAST_HALF_MS  = 50;
   localparam int SLOW_HALF_MS  = 250;
   localparam int STRETCH0_CYC  = STRETCH0_MS * (CLK_HZ / 1000);
   localparam int STRETCH1_CYC  = STRETCH1_MS * (CLK_HZ / 1000);
   localparam int STRETCH2_CYC  = STRETCH2_MS * (CLK_HZ / 1000);
   localparam int FAST_HALF_CYC = FAST_HALF_MS * (CLK_HZ / 1000);
   localparam int SLOW_HALF_CYC = SLOW_HALF_MS * (CLK_HZ / 1000);
   localparam int CNT_W         = 24;
   localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
   localparam logic [CNT_W-1:0] CNT_ONE  = 24'h000001;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic speed_100;
      logic tx_active;
      logic rx_active;
      logic collision;
      logic link_up;
      logic full_duplex;
   } ios_status_type;

   typedef struct packed {
      logic tx;
      logic rx;
      logic col;
      logic act;
   } ios_events_type;

endpackage

//--- design/ios_stretcher.sv
// retriggerable pulse stretcher
`timescale 1ns/1ps
`default_nettype none
module ios_stretcher
(
   input  wire logic                     sys_clk,
   input  wire logic                     reset_n,
   input  wire logic                     event_in,
   input  wire logic [ios_pkg::CNT_W-1:0] duration,
   output logic                          stretched
);
   import ios_pkg::*;

   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;

   // ************************************************************
   // hold count
   // ************************************************************
   always_comb
   begin
      count_next = count_reg;
      if (event_in)
         count_next = duration; // RULE10
      else if (count_reg != CNT_ZERO)
         count_next = count_reg - CNT_ONE;
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         count_reg <= CNT_ZERO;
      else
         count_reg <= count_next;
   end

   assign stretched = event_in || (count_reg != CNT_ZERO); // RULE3

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   property p_load;
      event_in |=> (count_reg == $past(duration));
   endproperty
   a_load: assert property (p_load) else $error("stretch count not loaded"); // RULE10

   property p_hold;
      (event_in && duration > CNT_ONE) |=> stretched [*2];
   endproperty
   a_hold: assert property (p_hold) else $error("stretch ended early"); // RULE3

endmodule // ios_stretcher
`default_nettype wire

//--- design/ios_blinker.sv
// free-running square wave for test blink patterns
`timescale 1ns/1ps
`default_nettype none
module ios_blinker
#(
   parameter int unsigned HALF_CYC = 8
)
(
   input  wire logic sys_clk,
   input  wire logic reset_n,
   output logic      blink
);
   import ios_pkg::*;

   localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF_CYC - 1);

   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic             blink_reg;
   logic             blink_next;

   // ************************************************************
   // divider
   // ************************************************************
   always_comb
   begin
      count_next = count_reg + CNT_ONE;
      blink_next = blink_reg;
      if (count_reg >= LAST)
      begin
         count_next = CNT_ZERO;
         blink_next = !blink_reg; // RULE13
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count_reg <= CNT_ZERO;
         blink_reg <= 1'b0;
      end
      else
      begin
         count_reg <= count_next;
         blink_reg <= blink_next;
      end
   end

   assign blink = blink_reg;

   property p_period;
      @(posedge sys_clk) disable iff (!reset_n)
      $changed(blink_reg) |-> ($past(count_reg) >= LAST);
   endproperty
   a_period: assert property (p_period) else $error("blink toggled off period"); // RULE13

endmodule // ios_blinker
`default_nettype wire

//--- tb/ios_lamp_model.sv
// lamp model on the three indicator outputs
`timescale 1ns/1ps
`default_nettype none
module ios_lamp_model
(
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   input  wire logic [2:0] indicator_on,
   output logic [2:0]      lit
);
   // lamp follows its drive pin, dark in reset
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         lit <= 3'h0;
      else
         lit <= indicator_on;
   end
endmodule // ios_lamp_model
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the indicator output selector
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ios_pkg::*;
   // ************************************************************
   // signals
   // ************************************************************
   localparam int D0 = 20;
   localparam int D1 = 40;
   localparam int D2 = 60;
   localparam int FH = 8;
   localparam int SH = 32;
   logic           sys_clk     = 1'b0;
   logic           reset_n     = 1'b0;
   logic [4:0]     reg_addr    = 5'h00;
   logic           reg_wr_en   = 1'b0;
   logic [15:0]    reg_wr_data = 16'h0000;
   logic [15:0]    reg_rd_data;
   ios_status_type status      = '0;
   logic [2:0]     indicator_on;
   logic [2:0]     lit;
   int             num_errors  = 0;
   int             comparisons = 0;
   integer         seed        = 80365;
   logic [31:0]    r;
   logic [15:0]    w;
   ios_status_type st;
   ios_status_type ev;
   logic [3:0]     cs [15];
   int             dl;

   ios_indicator_selector #(.STRETCH0(D0), .STRETCH1(D1), .STRETCH2(D2),
                            .FAST_HALF(FH), .SLOW_HALF(SH)) uut
   (
      .sys_clk      (sys_clk),
      .reset_n      (reset_n),
      .reg_addr     (reg_addr),
      .reg_wr_en    (reg_wr_en),
      .reg_wr_data  (reg_wr_data),
      .reg_rd_data  (reg_rd_data),
      .status       (status),
      .indicator_on (indicator_on)
   );

   ios_lamp_model lamps
   (
      .sys_clk      (sys_clk),
      .reset_n      (reset_n),
      .indicator_on (indicator_on),
      .lit          (lit)
   );

   always #10 sys_clk = ~sys_clk;

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask

   task automatic ck_ind(input logic [2:0] e, input string what);
      check({13'h0000, indicator_on}, {13'h0000, e}, what);
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wr_en <= 1'b1;
      reg_wr_data <= d;
      @(posedge sys_clk);
      reg_wr_en <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask

   task automatic rd_check(input logic [4:0] a, input logic [15:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      @(posedge sys_clk);
      #1 check(reg_rd_data, e, "register read");
   endtask

   function automatic logic [15:0] cfg(logic [3:0] a, logic [3:0] b, logic [3:0] c,
                                       logic [1:0] d, logic en);
      return {a, b, c, d, en, 1'b0};
   endfunction

   // unused source codes 0110 and 1111 never programmed
   function automatic logic [15:0] legal(logic [15:0] v);
      for (int k = 4; k < 16; k += 4)
         if (v[k +: 4] == 4'h6 || v[k +: 4] == 4'hf)
            v[k +: 4] = v[k +: 4] - 4'h1;
      return v;
   endfunction

   function automatic logic exp_cont(logic [3:0] c, ios_status_type s);
      case (c)
         SRC_SPEED:  return s.speed_100;
         SRC_TX:     return s.tx_active;
         SRC_RX:     return s.rx_active;
         SRC_COL:    return s.collision;
         SRC_LINK:   return s.link_up;
         SRC_DUPLEX: return s.full_duplex;
         SRC_ACT:    return s.tx_active | s.rx_active;
         SRC_ON:     return 1'b1;
         default:    return 1'b0;
      endcase
   endfunction

   task automatic apply(input ios_status_type v);
      @(posedge sys_clk);
      status <= v;
      @(posedge sys_clk);
      #1;
   endtask

   task automatic pulse(input ios_status_type base, input ios_status_type e);
      @(posedge sys_clk);
      status <= base | e;
      @(posedge sys_clk);
      status <= base;
   endtask

   task automatic measure(input int b, input int half);
      logic v;
      int   n;
      n = 0;
      @(posedge sys_clk);
      #1 v = lit[b];
      while (lit[b] === v && n < 200)
      begin
         @(posedge sys_clk);
         #1 n++;
      end
      v = lit[b];
      n = 0;
      while (lit[b] === v && n < 200)
      begin
         @(posedge sys_clk);
         #1 n++;
      end
      check(n[15:0], half[15:0], "blink half period");
   endtask

   task automatic wrap_up;
      $display("counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ************************************************************
   // tests
   // ************************************************************
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      $display("watchdog expired");
      wrap_up();
   end

   initial
   begin
      cs = '{SRC_SPEED, SRC_TX, SRC_RX, SRC_COL, SRC_LINK, SRC_DUPLEX, SRC_OFF, SRC_ACT,
             SRC_ON, SRC_OFF, SRC_SLOW, SRC_FAST, SRC_LINK, SRC_DUPLEX, SRC_SPEED};
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      // reset defaults, unmapped read, masked write-back
      rd_check(CFG_ADDR, 16'h0422);
      rd_check(5'h13, 16'h0000);
      st = '0;
      st.speed_100 = 1'b1;
      st.link_up = 1'b1;
      apply(st);
      ck_ind(3'h3, "default sources");
      wr(5'h13, 16'h1234);
      rd_check(CFG_ADDR, 16'h0422);
      repeat (4)
      begin
         r = $random(seed);
         w = legal(r[15:0]);
         wr(CFG_ADDR, w);
         rd_check(CFG_ADDR, w & 16'hfffe);
      end
      $display("end of test registers");
      // continuous codes, random status; stretching off except last group
      for (int i = 0; i < 15; i += 3)
      begin
         if (i == 9)
            continue;
         wr(CFG_ADDR, cfg(cs[i], cs[i+1], cs[i+2], 2'h0, i == 12));
         repeat (8)
         begin
            r = $random(seed);
            st = ios_status_type'(r[5:0]);
            apply(st);
            ck_ind({exp_cont(cs[i+2], st), exp_cont(cs[i+1], st), exp_cont(cs[i], st)},
                   "continuous source");
         end
      end
      wr(CFG_ADDR, cfg(SRC_ON, SRC_OFF, SRC_OFF, 2'h1, 1'b0));
      apply('1);
      ck_ind(3'h1, "on off forced");
      $display("end of test continuous");
      // stretched events at every duration code
      // quiet status long enough for every stretcher to run out
      apply('0);
      repeat (D2) @(posedge sys_clk);
      for (int d = 0; d < 4; d++)
      begin
         dl = (d == 0) ? D0 : (d == 1) ? D1 : D2;
         w = cfg(SRC_TX, SRC_RX, SRC_ACT, 2'(d), 1'b1);
         wr(CFG_ADDR, w);
         ev = '0;
         ev.tx_active = d[0];
         ev.rx_active = !d[0];
         pulse('0, ev);
         repeat (dl - 1) @(posedge sys_clk);
         #1 ck_ind(d[0] ? 3'h5 : 3'h6, "stretch held");
         repeat (3) @(posedge sys_clk);
         #1 ck_ind(3'h0, "stretch ended");
      end
      $display("end of test stretch");
      // combined displays with global stretching off
      wr(CFG_ADDR, cfg(SRC_LINK_RX, SRC_LINK_ACT, SRC_DUP_COL, 2'h0, 1'b0));
      st = '0;
      st.link_up = 1'b1;
      st.full_duplex = 1'b1;
      apply(st);
      ck_ind(3'h7, "combined primary");
      for (int e = 0; e < 3; e++)
      begin
         ev = '0;
         ev.rx_active = (e == 0);
         ev.tx_active = (e == 1);
         ev.collision = (e == 2);
         pulse(st, ev);
         repeat (D0 - 1) @(posedge sys_clk);
         #1 ck_ind((e == 0) ? 3'h4 : (e == 1) ? 3'h5 : 3'h3, "combined blink");
         repeat (3) @(posedge sys_clk);
         #1 ck_ind(3'h7, "combined settled");
      end
      apply('0);
      ck_ind(3'h0, "combined idle");
      $display("end of test combined");
      // blink patterns
      wr(CFG_ADDR, cfg(SRC_FAST, SRC_SLOW, SRC_OFF, 2'h0, 1'b1));
      measure(0, FH);
      measure(1, SH);
      $display("end of test blink");
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
